/* File: rtl/conv_ctrl_regs.sv */
// Control registers of both step-down converters: limits, ramp rates, mode, enable and voltage code.
// Assumes a single-cycle register port from the serial interface on ref_clk, and an external enable pin.
//
// What this block does
// [RULE_01] Limit codes 0-3 select 1.5 to 3.0 A
// [RULE_02] Limit changes apply while converter runs
// [RULE_03] Ramp codes 2-7 select 10 to 0.47 mV/us
// [RULE_04] Second converter ramp uses same encoding
// [RULE_05] Mode bit selects auto or forced PWM
// [RULE_06] Discharge only when disabled and enabled bit
// [RULE_07] Pin gating ANDs enable bit with pin
// [RULE_08] Enable bit turns second converter on
// [RULE_09] Voltage codes below 0x14 are undefined
// [RULE_10] Codes 0x14-0x17 step 10 mV from 0.7 V
// [RULE_11] Codes 0x18-0x9D step 5 mV from 0.735 V
// [RULE_12] Codes 0x9E-0xFF step 20 mV from 1.42 V
// [RULE_13] Host avoids reserved codes and bits
`timescale 1ns/100ps
module conv_ctrl_regs (
  input  wire logic        ref_clk,              // 10 MHz clock
  input  wire logic        nrst,                 // Async reset, active low
  input  wire logic        reg_wr,               // Register write strobe
  input  wire logic        reg_rd,               // Register read strobe
  input  wire logic [7:0]  reg_addr,             // Register address
  input  wire logic [7:0]  reg_wdata,            // Write data
  output logic      [7:0]  reg_rdata,            // Read data, registered
  output logic             reg_rvalid,           // Read data valid pulse
  input  wire logic        en_pin,               // External enable pin, asynchronous
  output logic      [3:0]  conv_a_current_limit, // One-hot limit select
  output logic      [5:0]  conv_a_ramp_rate,     // One-hot ramp select
  output logic      [3:0]  conv_b_current_limit, // One-hot limit select
  output logic      [5:0]  conv_b_ramp_rate,     // One-hot ramp select
  output logic             conv_a_codes_ok,      // Limit and ramp codes defined
  output logic             conv_b_codes_ok,      // Limit and ramp codes defined
  output logic             conv_b_forced_pwm,    // Forced PWM mode
  output logic             conv_b_run,           // Converter running
  output logic             conv_b_discharge,     // Discharge resistor connected
  output logic      [11:0] conv_a_target_mv,     // Target output in mV
  output logic             conv_a_vcode_ok       // Voltage code defined
);
  logic [7:0] a_limit_slew_q;
  logic [7:0] b_mode_enable_q;
  logic [7:0] b_limit_slew_q;
  logic [7:0] a_vcode_q;
  logic [1:0] pin_sync_q;
  logic       run_q;
  logic       run_d;
  logic [7:0] rdata_d;
  logic [3:0] a_lim;
  logic [5:0] a_ramp;
  logic [3:0] b_lim;
  logic [5:0] b_ramp;
  logic       a_ok;
  logic       b_ok;

  // Address match helper, shared by write and read paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_off);
    hit = (addr == reg_off);
  endfunction

  // Code to millivolt mapping over the three segments
  function automatic logic [11:0] code_to_mv(input logic [7:0] code);
    logic [7:0] off;
    off = 8'h00;
    code_to_mv = 12'h000;
    if (code >= conv_regs_pkg::vcode_coarse) begin
      off = code - conv_regs_pkg::vcode_coarse;
      code_to_mv = conv_regs_pkg::mv_base_c + 12'(off) * 12'(conv_regs_pkg::mv_step_c);
    end else if (code >= conv_regs_pkg::vcode_fine_lo) begin
      off = code - conv_regs_pkg::vcode_fine_lo;
      code_to_mv = conv_regs_pkg::mv_base_b + 12'(off) * 12'(conv_regs_pkg::mv_step_b);
    end else if (code >= conv_regs_pkg::vcode_first) begin
      off = code - conv_regs_pkg::vcode_first;
      code_to_mv = conv_regs_pkg::mv_base_a + 12'(off) * 12'(conv_regs_pkg::mv_step_a);
    end
  endfunction

  // [RULE_02] Live limit writes
  // Writes land at any time; no enable interlock, so the new limit applies next cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      a_limit_slew_q <= conv_regs_pkg::limit_slew_rst;
      b_limit_slew_q <= conv_regs_pkg::limit_slew_rst;
    end else if (reg_wr) begin
      if (hit(reg_addr, conv_regs_pkg::conv_a_limit_slew_addr)) begin
        a_limit_slew_q <= reg_wdata & conv_regs_pkg::limit_slew_mask;
      end
      if (hit(reg_addr, conv_regs_pkg::conv_b_limit_slew_addr)) begin
        b_limit_slew_q <= reg_wdata & conv_regs_pkg::limit_slew_mask;
      end
    end
  end

  // Mode and enable register; reserved high nibble stays zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      b_mode_enable_q <= conv_regs_pkg::mode_enable_rst;
    end else if (reg_wr && hit(reg_addr, conv_regs_pkg::conv_b_mode_enable_addr)) begin
      b_mode_enable_q <= reg_wdata & conv_regs_pkg::mode_enable_mask;
    end
  end

  // Voltage code register, all eight bits writable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      a_vcode_q <= conv_regs_pkg::voltage_code_rst;
    end else if (reg_wr && hit(reg_addr, conv_regs_pkg::conv_a_voltage_code_addr)) begin
      a_vcode_q <= reg_wdata;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (hit(reg_addr, conv_regs_pkg::conv_a_limit_slew_addr)) begin
      rdata_d = a_limit_slew_q;
    end else if (hit(reg_addr, conv_regs_pkg::conv_b_mode_enable_addr)) begin
      rdata_d = b_mode_enable_q;
    end else if (hit(reg_addr, conv_regs_pkg::conv_b_limit_slew_addr)) begin
      rdata_d = b_limit_slew_q;
    end else if (hit(reg_addr, conv_regs_pkg::conv_a_voltage_code_addr)) begin
      rdata_d = a_vcode_q;
    end
  end

  // Read data is held until the next read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // Pin synchroniser; the pin is asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_sync_q <= 2'b00;
    end else begin
      pin_sync_q <= {pin_sync_q[0], en_pin};
    end
  end

  // [RULE_07] Pin gating of enable
  // [RULE_08] Enable bit control
  always_comb begin
    run_d = b_mode_enable_q[conv_regs_pkg::on_bit];
    if (b_mode_enable_q[conv_regs_pkg::pin_gating_bit]) begin
      run_d = run_d & pin_sync_q[1];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run_d;
    end
  end

  // Setpoint decode for converter A
  conv_setpoint_decode u_dec_a (
    .limit_code (a_limit_slew_q[conv_regs_pkg::limit_lsb +: 3]),
    .ramp_code  (a_limit_slew_q[conv_regs_pkg::ramp_lsb +: 3]),
    .limit_sel  (a_lim),
    .ramp_sel   (a_ramp),
    .code_ok    (a_ok)
  );

  // [RULE_04] Same ramp encoding for B
  conv_setpoint_decode u_dec_b (
    .limit_code (b_limit_slew_q[conv_regs_pkg::limit_lsb +: 3]),
    .ramp_code  (b_limit_slew_q[conv_regs_pkg::ramp_lsb +: 3]),
    .limit_sel  (b_lim),
    .ramp_sel   (b_ramp),
    .code_ok    (b_ok)
  );

  // Decoded controls are registered so the analog side sees clean levels
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv_a_current_limit <= 4'h0;
      conv_a_ramp_rate     <= 6'h00;
      conv_b_current_limit <= 4'h0;
      conv_b_ramp_rate     <= 6'h00;
      conv_a_codes_ok      <= 1'b0;
      conv_b_codes_ok      <= 1'b0;
    end else begin
      conv_a_current_limit <= a_lim;
      conv_a_ramp_rate     <= a_ramp;
      conv_b_current_limit <= b_lim;
      conv_b_ramp_rate     <= b_ramp;
      conv_a_codes_ok      <= a_ok;
      conv_b_codes_ok      <= b_ok;
    end
  end

  // [RULE_05] Forced PWM select
  // [RULE_06] Discharge when disabled
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv_b_forced_pwm <= 1'b0;
      conv_b_run        <= 1'b0;
      conv_b_discharge  <= 1'b0;
    end else begin
      conv_b_forced_pwm <= b_mode_enable_q[conv_regs_pkg::forced_pwm_bit];
      conv_b_run        <= run_q;
      conv_b_discharge  <= ~run_q & b_mode_enable_q[conv_regs_pkg::discharge_bit];
    end
  end

  // [RULE_09] Undefined low codes
  // [RULE_10] 10 mV segment
  // [RULE_11] 5 mV segment
  // [RULE_12] 20 mV segment
  // Reserved codes give 0 mV and a low flag rather than a guessed level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conv_a_target_mv <= 12'h000;
      conv_a_vcode_ok  <= 1'b0;
    end else begin
      conv_a_target_mv <= code_to_mv(a_vcode_q);
      conv_a_vcode_ok  <= (a_vcode_q >= conv_regs_pkg::vcode_first);
    end
  end
endmodule // conv_ctrl_regs

/* File: shared/conv_regs_pkg.sv */
// Register map, field layout, reset values and decode constants for the converter control registers.
// Assumes an 8-bit register port driven by the serial interface front end on the same clock.
package conv_regs_pkg;
  // Register offsets
  localparam logic [7:0] conv_a_limit_slew_addr   = 8'h03;
  localparam logic [7:0] conv_b_mode_enable_addr  = 8'h04;
  localparam logic [7:0] conv_b_limit_slew_addr   = 8'h05;
  localparam logic [7:0] conv_a_voltage_code_addr = 8'h06;
  // Field positions
  localparam int ramp_lsb       = 0;
  localparam int limit_lsb      = 3;
  localparam int on_bit         = 0;
  localparam int pin_gating_bit = 1;
  localparam int discharge_bit  = 2;
  localparam int forced_pwm_bit = 3;
  // Writable masks; reserved bits are held at zero
  localparam logic [7:0] limit_slew_mask  = 8'h3F;
  localparam logic [7:0] mode_enable_mask = 8'h0F;
  // Reset values; only the discharge enable is defined as one
  localparam logic [7:0] limit_slew_rst   = 8'h00;
  localparam logic [7:0] mode_enable_rst  = 8'h04;
  localparam logic [7:0] voltage_code_rst = 8'h00;
  // Code ranges
  localparam logic [2:0] limit_max_code = 3'h3;
  localparam logic [2:0] ramp_min_code  = 3'h2;
  localparam logic [7:0] vcode_first    = 8'h14;
  localparam logic [7:0] vcode_fine_lo  = 8'h18;
  localparam logic [7:0] vcode_coarse   = 8'h9E;
  // Output levels in millivolts at each segment start, and step sizes
  localparam logic [11:0] mv_base_a  = 12'h2BC; // 700 mV
  localparam logic [11:0] mv_base_b  = 12'h2DF; // 735 mV
  localparam logic [11:0] mv_base_c  = 12'h58C; // 1420 mV
  localparam logic [4:0]  mv_step_a  = 5'h0A;
  localparam logic [4:0]  mv_step_b  = 5'h05;
  localparam logic [4:0]  mv_step_c  = 5'h14;
endpackage

/* File: rtl/conv_setpoint_decode.sv */
// Decodes one converter's limit and ramp codes into one-hot selects and a validity flag.
// Assumes the codes come from registers on the same clock; purely combinational.
`timescale 1ns/100ps
module conv_setpoint_decode (
  input  wire logic [2:0] limit_code,  // Current limit code
  input  wire logic [2:0] ramp_code,   // Ramp rate code
  output logic      [3:0] limit_sel,   // One-hot 1.5/2.0/2.5/3.0 A
  output logic      [5:0] ramp_sel,    // One-hot 10..0.47 mV/us
  output logic            code_ok      // Both codes defined
);
  // [RULE_01] Limit code decode
  always_comb begin
    limit_sel = 4'h0;
    if (limit_code <= conv_regs_pkg::limit_max_code) begin
      limit_sel[limit_code[1:0]] = 1'b1;
    end
  end
  // [RULE_03] Ramp code decode
  always_comb begin
    ramp_sel = 6'h00;
    if (ramp_code >= conv_regs_pkg::ramp_min_code) begin
      ramp_sel[3'(ramp_code - conv_regs_pkg::ramp_min_code)] = 1'b1;
    end
  end
  // Reserved codes leave every select low, so the flag follows them
  assign code_ok = (|limit_sel) & (|ramp_sel);
endmodule // conv_setpoint_decode

/* File: testbench/conv_ctrl_regs_asserts.sv */
// Port checker for the converter control registers.
// Assumes binding to conv_ctrl_regs; one clock domain, ref_clk.
`timescale 1ns/100ps
module conv_ctrl_regs_asserts (
  input wire logic        ref_clk,              // Clock
  input wire logic        nrst,                 // Reset, active low
  input wire logic        reg_wr,               // Write strobe
  input wire logic        reg_rd,               // Read strobe
  input wire logic [7:0]  reg_addr,             // Address
  input wire logic [7:0]  reg_wdata,            // Write data
  input wire logic        reg_rvalid,           // Read answer
  input wire logic [3:0]  conv_a_current_limit, // Limit select
  input wire logic [5:0]  conv_a_ramp_rate,     // Ramp select
  input wire logic [3:0]  conv_b_current_limit, // Limit select
  input wire logic [5:0]  conv_b_ramp_rate,     // Ramp select
  input wire logic        conv_a_codes_ok,      // Codes defined
  input wire logic        conv_b_codes_ok,      // Codes defined
  input wire logic        conv_b_forced_pwm,    // Forced PWM
  input wire logic        conv_b_run,           // Running
  input wire logic        conv_b_discharge,     // Discharge on
  input wire logic [11:0] conv_a_target_mv,     // Target level
  input wire logic        conv_a_vcode_ok       // Code defined
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Defined codes must select exactly one limit and one ramp
  a_codes_a: assert property (
    conv_a_codes_ok |-> $onehot(conv_a_current_limit) && $onehot(conv_a_ramp_rate)) else $error("a select not one-hot");
  a_reserved_a: assert property (
    !conv_a_codes_ok |-> (conv_a_current_limit == 4'h0 || conv_a_ramp_rate == 6'h00)) else $error("a reserved code ok");
  b_codes_a: assert property (
    conv_b_codes_ok |-> $onehot(conv_b_current_limit) && $onehot(conv_b_ramp_rate)) else $error("b select not one-hot");
  // Decoded mode follows the written bit two edges later unless overwritten
  mode_write_a: assert property (
    reg_wr && reg_addr == 8'h04 ##1 !(reg_wr && reg_addr == 8'h04) |=> conv_b_forced_pwm == $past(reg_wdata[3], 2))
    else $error("forced pwm mismatch");
  // Without pin gating the run output follows the enable bit three edges after the write
  enable_write_a: assert property (
    reg_wr && reg_addr == 8'h04 && !reg_wdata[1] ##1 !(reg_wr && reg_addr == 8'h04) |-> ##2
      conv_b_run == $past(reg_wdata[0], 3))
    else $error("enable bit not followed");
  discharge_off_a: assert property (
    conv_b_discharge |-> !conv_b_run) else $error("discharge while running");
  vcode_write_a: assert property (
    reg_wr && reg_addr == 8'h06 ##1 !(reg_wr && reg_addr == 8'h06) |=> conv_a_vcode_ok == ($past(reg_wdata, 2) >= 8'h14))
    else $error("voltage code validity mismatch");
  mv_zero_a: assert property (
    !conv_a_vcode_ok |-> conv_a_target_mv == 12'h000) else $error("reserved code gives a level");
  mv_range_a: assert property (
    conv_a_vcode_ok |-> conv_a_target_mv >= 12'h2BC && conv_a_target_mv <= 12'hD20) else $error("level out of range");
  read_answer_a: assert property (
    reg_rd |=> reg_rvalid) else $error("read without answer");
endmodule // conv_ctrl_regs_asserts

/* File: testbench/host_port_model.sv */
// Host model on the register port: single-cycle write and read strobes.
// Assumes the block answers a read at the strobe edge, settled 10 ns later.
`timescale 1ns/100ps
module host_port_model (
  input  wire logic       ref_clk,    // Clock
  input  wire logic [7:0] reg_rdata,  // Read data
  input  wire logic       reg_rvalid, // Read answer
  output logic            reg_wr,     // Write strobe
  output logic            reg_rd,     // Read strobe
  output logic [7:0]      reg_addr,   // Address
  output logic [7:0]      reg_wdata   // Write data
);
  // Idle port; released lines show inverted values so stale data never matches
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #10;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #10;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Answer is registered at the strobe edge, so it is settled 10 ns later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #10;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #10;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule // host_port_model

/* File: testbench/test_conv_ctrl_regs.sv */
// Self-checking bench for the converter control registers.
// Assumes the host model owns the register port; en_pin is driven here.
`timescale 1ns/100ps
module test_conv_ctrl_regs;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        en_pin = 1'b0;
  logic        reg_wr, reg_rd, reg_rvalid, conv_a_codes_ok, conv_b_codes_ok, conv_b_forced_pwm;
  logic        conv_b_run, conv_b_discharge, conv_a_vcode_ok;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [3:0]  conv_a_current_limit, conv_b_current_limit;
  logic [5:0]  conv_a_ramp_rate, conv_b_ramp_rate;
  logic [11:0] conv_a_target_mv;
  logic [7:0]  vcodes [8] = '{8'h00, 8'h13, 8'h14, 8'h17, 8'h18, 8'h9D, 8'h9E, 8'hFF};
  int          error_cnt = 0;
  int          comparisons = 0;
  logic [2:0]  lc, rc;
  conv_ctrl_regs u_conv_ctrl_regs (.ref_clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .en_pin, .conv_a_current_limit, .conv_a_ramp_rate, .conv_b_current_limit, .conv_b_ramp_rate, .conv_a_codes_ok,
    .conv_b_codes_ok, .conv_b_forced_pwm, .conv_b_run, .conv_b_discharge, .conv_a_target_mv, .conv_a_vcode_ok);
  host_port_model u_host_port_model (.ref_clk, .reg_rdata, .reg_rvalid, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
  // 100 ns period
  always #50 ref_clk = ~ref_clk;
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Three edges cover the two-edge decode delay of run and discharge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host_port_model.wr(a, d);
    repeat (3) @(posedge ref_clk);
    #10;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host_port_model.rd(a, rd_val);
    chk({4'h0, rd_val}, {4'h0, exp});
  endtask
  // Level expected from the three step segments; zero for reserved codes
  function automatic logic [11:0] mv(input logic [7:0] c);
    if (c < 8'h14) return 12'h000;
    if (c < 8'h18) return 12'h2BC + 12'h00A * (c - 8'h14);
    if (c < 8'h9E) return 12'h2DF + 12'h005 * (c - 8'h18);
    return 12'h58C + 12'h014 * (c - 8'h9E);
  endfunction
  task automatic results;
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    #10 nrst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #10;
    chk(conv_b_discharge, 1'b1);
    for (int i = 3; i < 7; i++) rchk(i[7:0], (i == 4) ? 8'h04 : 8'h00);
    // Reserved bits stay zero; unmapped places ignore writes and read zero
    wr(8'h03, 8'hFF);
    rchk(8'h03, 8'h3F);
    wr(8'h04, 8'hF6);
    rchk(8'h04, 8'h06);
    wr(8'h07, 8'h55);
    rchk(8'h07, 8'h00);
    // Each limit code paired with ramp code 7 minus it, both converters, fields swapped on B
    for (int i = 0; i < 8; i++) begin
      lc = i[2:0];
      rc = 3'h7 - i[2:0];
      wr(8'h03, {2'b00, lc, rc});
      wr(8'h05, {2'b00, rc, lc});
      chk(conv_a_current_limit, (lc <= 3'h3) ? (4'h1 << lc) : 4'h0);
      chk(conv_a_ramp_rate, (rc >= 3'h2) ? (6'h01 << (rc - 3'h2)) : 6'h00);
      chk(conv_a_codes_ok, lc <= 3'h3 && rc >= 3'h2);
      chk(conv_b_current_limit, (rc <= 3'h3) ? (4'h1 << rc) : 4'h0);
      chk(conv_b_ramp_rate, (lc >= 3'h2) ? (6'h01 << (lc - 3'h2)) : 6'h00);
      chk(conv_b_codes_ok, rc <= 3'h3 && lc >= 3'h2);
    end
    // Limit change while running, no disable in between
    wr(8'h04, 8'h01);
    chk(conv_b_run, 1'b1);
    wr(8'h05, 8'h1A);
    chk(conv_b_run, 1'b1);
    chk(conv_b_current_limit, 4'h8);
    // Pin gating holds the converter off until the pin rises
    wr(8'h04, 8'h07);
    chk(conv_b_run, 1'b0);
    chk(conv_b_discharge, 1'b1);
    en_pin = 1'b1;
    repeat (5) @(posedge ref_clk);
    #10;
    chk(conv_b_run, 1'b1);
    chk(conv_b_discharge, 1'b0);
    wr(8'h04, 8'h08);
    chk(conv_b_forced_pwm, 1'b1);
    chk(conv_b_run, 1'b0);
    chk(conv_b_discharge, 1'b0);
    wr(8'h04, 8'h04);
    chk(conv_b_forced_pwm, 1'b0);
    // Segment edges of the voltage code
    foreach (vcodes[i]) begin
      wr(8'h06, vcodes[i]);
      chk(conv_a_target_mv, mv(vcodes[i]));
      chk(conv_a_vcode_ok, vcodes[i] >= 8'h14);
    end
    // Reset in mid-run must bring back every reset value, discharge enable included
    nrst = 1'b0;
    repeat (2) @(posedge ref_clk);
    #10 nrst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #10;
    chk(conv_b_discharge, 1'b1);
    chk(conv_a_target_mv, 12'h000);
    for (int i = 3; i < 7; i++) rchk(i[7:0], (i == 4) ? 8'h04 : 8'h00);
    results();
  end
  // Whole sequence takes about 20 us
  initial begin
    #400000;
    error_cnt++;
    results();
  end
endmodule // test_conv_ctrl_regs
bind conv_ctrl_regs conv_ctrl_regs_asserts u_conv_ctrl_regs_asserts (.ref_clk, .nrst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rvalid, .conv_a_current_limit, .conv_a_ramp_rate, .conv_b_current_limit, .conv_b_ramp_rate,
  .conv_a_codes_ok, .conv_b_codes_ok, .conv_b_forced_pwm, .conv_b_run, .conv_b_discharge, .conv_a_target_mv,
  .conv_a_vcode_ok);
